//--- core/flrs_fan_ctrl.sv
// fan driver control: commutation, lock protection, standby, soft start
`timescale 1ns/1ns

// Behaviour
// - internal counter times shutdown and restart
// - locked rotor: outputs off five seconds
// - restart: A high, B low, half second
// - repeat cycle until rotation seen again
// - pwm low past window enters standby
// - standby: bridge and tach released
// - no lock detect in standby; immediate start
// - start-up duty at least half, 250 ms
// - high supply: 50% at 25 kHz
// - low supply: 20 us conduction per rise
// - fast low-duty pwm gives half duty
// - higher pwm duty passes unchanged
// - 50 kHz pwm gives full conduction
// - slow low-duty pwm may stay low
// - restart pulses use limited start-up drive
// - standby window never above 90 ms
module flrs_fan_ctrl #(
    parameter int unsigned OFF_CYC      = flrs_pkg::OFF_CYC,
    parameter int unsigned ON_CYC       = flrs_pkg::ON_CYC,
    parameter int unsigned QS_CYC       = flrs_pkg::QS_CYC,
    parameter int unsigned START_CYC    = flrs_pkg::START_CYC,
    parameter int unsigned LOCK_DET_CYC = flrs_pkg::LOCK_DET_CYC
) (
    // clock and reset
    input  logic clk,
    input  logic resetn,
    // host side
    input  logic pwmIn,
    output logic tachOutput,
    output logic tachOutputEn,
    // hall comparator and supply monitor
    input  logic hallPos,
    input  logic supplyHigh,
    output logic hallAmpEn,
    // motor bridge
    output logic bridgeOutA,
    output logic bridgeOutB,
    output logic bridgeOutEn
);
    flrs_pkg::flrs_pins_t       pinsSync;
    logic [flrs_pkg::PIN_W-1:0] pinsVec;
    logic                       pwmLast;
    logic                       hallLast;
    logic                       pwmRise;
    logic                       rotation;
    logic                       bootReg;
    logic                       startReq;
    logic                       startActive;
    logic                       startGate;
    logic                       gate;
    logic                       standbyHit;
    logic [flrs_pkg::CNT_W-1:0] lowCntReg;
    logic [flrs_pkg::CNT_W-1:0] timerReg;
    logic [flrs_pkg::CNT_W-1:0] stallReg;
    flrs_pkg::flrs_state_t      stateReg;
    flrs_pkg::flrs_state_t      stateNext;
    flrs_pkg::flrs_bridge_t     bridgeReg;
    flrs_pkg::flrs_bridge_t     bridgeNext;
    logic                       tachEnReg;
    logic                       tachEnNext;
    logic                       hallAmpReg;

    // pins into the clock domain
    flrs_sync u_sync (
        .clk     (clk),
        .resetn  (resetn),
        .pinRaw  ({pwmIn, hallPos, supplyHigh}),
        .pinSync (pinsVec)
    );
    assign pinsSync = flrs_pkg::flrs_pins_t'(pinsVec);

    // edge history of pwm and hall
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwmLast  <= 1'b0;
            hallLast <= 1'b0;
        end else begin
            pwmLast  <= pinsSync.pwm;
            hallLast <= pinsSync.hallPos;
        end
    end
    assign pwmRise  = pinsSync.pwm && !pwmLast;
    // hall amplifier is off in standby, so no rotation is seen there
    assign rotation = (pinsSync.hallPos != hallLast) && (stateReg != flrs_pkg::ST_STANDBY);

    // pwm low-time counter, saturates at the quick-start window
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lowCntReg <= '0;
        end else if (pinsSync.pwm) begin
            lowCntReg <= '0;
        end else if (lowCntReg != QS_CYC - 1) begin
            lowCntReg <= lowCntReg + 32'h1;
        end
    end
    assign standbyHit = !pinsSync.pwm && lowCntReg == QS_CYC - 1;

    // time spent in the present state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            timerReg <= '0;
        end else if (stateNext != stateReg) begin
            timerReg <= '0;
        end else begin
            timerReg <= timerReg + 32'h1;
        end
    end

    // time since the last hall change while running
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stallReg <= '0;
        end else if (rotation || stateReg != flrs_pkg::ST_RUN) begin
            stallReg <= '0;
        end else if (stallReg != LOCK_DET_CYC - 1) begin
            stallReg <= stallReg + 32'h1;
        end
    end

    // mode sequencing
    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            flrs_pkg::ST_RUN: begin
                if (standbyHit) begin
                    stateNext = flrs_pkg::ST_STANDBY;
                end else if (stallReg == LOCK_DET_CYC - 1) begin
                    stateNext = flrs_pkg::ST_LOCK_OFF;
                end
            end
            flrs_pkg::ST_LOCK_OFF: begin
                if (standbyHit) begin
                    stateNext = flrs_pkg::ST_STANDBY;
                end else if (rotation) begin
                    stateNext = flrs_pkg::ST_RUN;
                end else if (timerReg == OFF_CYC - 1) begin
                    stateNext = flrs_pkg::ST_RESTART;
                end
            end
            flrs_pkg::ST_RESTART: begin
                if (standbyHit) begin
                    stateNext = flrs_pkg::ST_STANDBY;
                end else if (rotation) begin
                    stateNext = flrs_pkg::ST_RUN;
                end else if (timerReg == ON_CYC - 1) begin
                    stateNext = flrs_pkg::ST_LOCK_OFF;
                end
            end
            flrs_pkg::ST_STANDBY: begin
                if (pinsSync.pwm) begin
                    stateNext = flrs_pkg::ST_RUN;
                end
            end
            default: begin
                stateNext = flrs_pkg::RST_STATE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stateReg <= flrs_pkg::RST_STATE;
        end else begin
            stateReg <= stateNext;
        end
    end

    // start from a stopped motor: after reset, standby exit, each restart
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bootReg <= 1'b1;
        end else begin
            bootReg <= 1'b0;
        end
    end
    assign startReq = bootReg
        || (stateReg == flrs_pkg::ST_STANDBY && stateNext == flrs_pkg::ST_RUN)
        || (stateReg != flrs_pkg::ST_RESTART && stateNext == flrs_pkg::ST_RESTART);

    flrs_startup #(
        .START_CYC (START_CYC)
    ) u_startup (
        .clk        (clk),
        .resetn     (resetn),
        .startReq   (startReq),
        .rotation   (rotation),
        .supplyHigh (pinsSync.supplyHigh),
        .pwmLevel   (pinsSync.pwm),
        .pwmRise    (pwmRise),
        .active     (startActive),
        .driveGate  (startGate)
    );
    assign gate = startActive ? startGate : pinsSync.pwm;

    // output decode per mode
    always_comb begin
        bridgeNext = flrs_pkg::RST_BRIDGE;
        tachEnNext = pinsSync.hallPos;
        case (stateReg)
            flrs_pkg::ST_RUN: begin
                bridgeNext.driveEn = 1'b1;
                bridgeNext.outA    = gate && pinsSync.hallPos;
                bridgeNext.outB    = gate && !pinsSync.hallPos;
            end
            flrs_pkg::ST_LOCK_OFF: begin
                bridgeNext.driveEn = 1'b1;
            end
            flrs_pkg::ST_RESTART: begin
                bridgeNext.driveEn = 1'b1;
                bridgeNext.outA    = startActive ? startGate : 1'b1;
            end
            flrs_pkg::ST_STANDBY: begin
                tachEnNext = 1'b0;
            end
            default: begin
                tachEnNext = 1'b0;
            end
        endcase
    end

    // registered pin drive
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bridgeReg  <= flrs_pkg::RST_BRIDGE;
            tachEnReg  <= 1'b0;
            hallAmpReg <= 1'b0;
        end else begin
            bridgeReg  <= bridgeNext;
            tachEnReg  <= tachEnNext;
            hallAmpReg <= stateNext != flrs_pkg::ST_STANDBY;
        end
    end

    assign bridgeOutA   = bridgeReg.outA;
    assign bridgeOutB   = bridgeReg.outB;
    assign bridgeOutEn  = bridgeReg.driveEn;
    assign tachOutput   = 1'b0; // open drain: only ever pulls low
    assign tachOutputEn = tachEnReg;
    assign hallAmpEn    = hallAmpReg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    off_to_restart_a: assert property (
        stateReg == flrs_pkg::ST_LOCK_OFF && timerReg == OFF_CYC - 1
        && !standbyHit && !rotation |=> stateReg == flrs_pkg::ST_RESTART)
        else $error("shutdown interval did not end in restart");
    lock_off_low_a: assert property (
        stateReg == flrs_pkg::ST_LOCK_OFF |=> !bridgeOutA && !bridgeOutB && bridgeOutEn)
        else $error("bridge driven during shutdown interval");
    restart_drive_a: assert property (
        stateReg == flrs_pkg::ST_RESTART && !startActive |=> bridgeOutA && !bridgeOutB)
        else $error("restart torque not applied");
    restart_end_a: assert property (
        stateReg == flrs_pkg::ST_RESTART && timerReg == ON_CYC - 1
        && !standbyHit && !rotation |=> stateReg == flrs_pkg::ST_LOCK_OFF)
        else $error("restart interval did not repeat shutdown");
    standby_entry_a: assert property (
        $rose(standbyHit) |=> stateReg == flrs_pkg::ST_STANDBY ##1 !hallAmpEn)
        else $error("standby not entered after low window");
    window_bound_a: assert property (
        lowCntReg < flrs_pkg::QS_MAX_CYC)
        else $error("standby window beyond worst case");
    standby_off_a: assert property (
        stateReg == flrs_pkg::ST_STANDBY |=> !bridgeOutEn && !tachOutputEn)
        else $error("outputs driven in standby");
    standby_exit_a: assert property (
        stateReg == flrs_pkg::ST_STANDBY && pinsSync.pwm
        |=> stateReg == flrs_pkg::ST_RUN && startActive)
        else $error("standby exit did not start fan");
    run_follow_a: assert property (
        stateReg == flrs_pkg::ST_RUN && !startActive && pinsSync.pwm
        |=> bridgeOutA == $past(pinsSync.hallPos) && tachOutputEn == bridgeOutA)
        else $error("commutation does not follow hall");
    run_pwm_low_a: assert property (
        stateReg == flrs_pkg::ST_RUN && !startActive && !pinsSync.pwm
        |=> !bridgeOutA && !bridgeOutB)
        else $error("bridge driven with pwm low");

    lock_cycle_c: cover property (
        stateReg == flrs_pkg::ST_LOCK_OFF ##1 stateReg == flrs_pkg::ST_RESTART);
    restart_run_c: cover property (
        stateReg == flrs_pkg::ST_RESTART ##1 stateReg == flrs_pkg::ST_RUN);
    standby_c: cover property (
        stateReg == flrs_pkg::ST_STANDBY ##1 stateReg == flrs_pkg::ST_RUN);
endmodule // flrs_fan_ctrl

//--- core/flrs_pkg.sv
// constants and types shared by the fan lock/restart/soft-start controller
package flrs_pkg;
    // clock rate
    localparam int unsigned CLK_KHZ        = 25000;
    localparam int unsigned CLK_MHZ        = CLK_KHZ / 1000;
    // lock shutdown interval and lock restart interval
    localparam int unsigned OFF_TIME_MS    = 5000;
    localparam int unsigned OFF_CYC        = CLK_KHZ * OFF_TIME_MS;
    localparam int unsigned ON_TIME_MS     = 500;
    localparam int unsigned ON_CYC         = CLK_KHZ * ON_TIME_MS;
    // quick-start window, nominal and worst case
    localparam int unsigned QS_TIME_US     = 66500;
    localparam int unsigned QS_CYC         = CLK_MHZ * QS_TIME_US;
    localparam int unsigned QS_MAX_MS      = 90;
    localparam int unsigned QS_MAX_CYC     = CLK_KHZ * QS_MAX_MS;
    // start-up limit and stall time that declares a locked rotor
    localparam int unsigned START_MS       = 250;
    localparam int unsigned START_CYC      = CLK_KHZ * START_MS;
    localparam int unsigned LOCK_DET_MS    = 500;
    localparam int unsigned LOCK_DET_CYC   = CLK_KHZ * LOCK_DET_MS;
    // low-supply conduction stretch and high-supply start-up chop rate
    localparam int unsigned STRETCH_US     = 20;
    localparam int unsigned STRETCH_CYC    = CLK_MHZ * STRETCH_US;
    localparam int unsigned START_KHZ      = 25;
    localparam int unsigned START_HALF_CYC = CLK_KHZ / (2 * START_KHZ);
    // widths
    localparam int unsigned CNT_W          = 32;
    localparam int unsigned PIN_W          = 3;

    typedef enum logic [1:0] {
        ST_RUN      = 2'h0,
        ST_LOCK_OFF = 2'h1,
        ST_RESTART  = 2'h3,
        ST_STANDBY  = 2'h2
    } flrs_state_t;

    localparam flrs_state_t RST_STATE = ST_RUN;

    // pin inputs from outside the clock domain
    typedef struct packed {
        logic pwm;
        logic hallPos;
        logic supplyHigh;
    } flrs_pins_t;

    // bridge drive: levels of both outputs and the common drive enable
    typedef struct packed {
        logic outA;
        logic outB;
        logic driveEn;
    } flrs_bridge_t;

    localparam flrs_bridge_t RST_BRIDGE = '{outA: 1'b0, outB: 1'b0, driveEn: 1'b0};
endpackage

//--- core/flrs_startup.sv
// start-up duty limiter: 50% chop at high supply, 20 us stretch at low supply
`timescale 1ns/1ns
module flrs_startup #(
    parameter int unsigned START_CYC = flrs_pkg::START_CYC
) (
    // clock and reset
    input  logic clk,
    input  logic resetn,
    // control
    input  logic startReq,
    input  logic rotation,
    input  logic supplyHigh,
    input  logic pwmLevel,
    input  logic pwmRise,
    // result
    output logic active,
    output logic driveGate
);
    logic [flrs_pkg::CNT_W-1:0] timeReg;
    logic [flrs_pkg::CNT_W-1:0] phaseReg;
    logic [flrs_pkg::CNT_W-1:0] stretchReg;
    logic                       activeReg;

    assign active = activeReg;

    // window opens on start, closes on rotation or at the limit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            activeReg <= 1'b0;
            timeReg   <= '0;
        end else if (startReq) begin
            activeReg <= 1'b1;
            timeReg   <= '0;
        end else if (activeReg) begin
            timeReg <= timeReg + 32'h1;
            if (rotation || timeReg == START_CYC - 1) begin
                activeReg <= 1'b0;
            end
        end
    end

    // 25 kHz chop phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phaseReg <= '0;
        end else if (startReq || phaseReg == 2 * flrs_pkg::START_HALF_CYC - 1) begin
            phaseReg <= '0;
        end else begin
            phaseReg <= phaseReg + 32'h1;
        end
    end

    // conduction stretch after each pwm rising edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stretchReg <= '0;
        end else if (pwmRise) begin
            stretchReg <= flrs_pkg::STRETCH_CYC;
        end else if (stretchReg != '0) begin
            stretchReg <= stretchReg - 32'h1;
        end
    end

    // gate: fixed 50% chop, or stretch then pwm level
    always_comb begin
        if (supplyHigh) begin
            driveGate = phaseReg < flrs_pkg::START_HALF_CYC;
        end else begin
            driveGate = (stretchReg != '0) || pwmLevel;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    start_bound_a: assert property (activeReg |-> timeReg < START_CYC)
        else $error("start-up window ran past its limit");
    chop_half_a: assert property (
        $fell(driveGate) && supplyHigh && $past(supplyHigh) && !$past(startReq)
        |-> phaseReg == flrs_pkg::START_HALF_CYC)
        else $error("start-up chop not 50 percent");
    stretch_hold_a: assert property (
        pwmRise && !supplyHigh ##1 !supplyHigh[*8] |-> driveGate)
        else $error("conduction not held after pwm rise");
    start_cov_c: cover property (activeReg && rotation);
endmodule // flrs_startup

//--- core/flrs_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module flrs_sync (
    // clock and reset
    input  logic                            clk,
    input  logic                            resetn,
    // raw pins and filtered levels
    input  logic [flrs_pkg::PIN_W-1:0]      pinRaw,
    output logic [flrs_pkg::PIN_W-1:0]      pinSync
);
    logic [flrs_pkg::PIN_W-1:0] s1Reg;
    logic [flrs_pkg::PIN_W-1:0] s2Reg;
    logic [flrs_pkg::PIN_W-1:0] s3Reg;

    // per pin: three flops, change accepted once stages two and three agree
    for (genvar i = 0; i < flrs_pkg::PIN_W; i++) begin : g_pin
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                s1Reg[i]   <= 1'b0;
                s2Reg[i]   <= 1'b0;
                s3Reg[i]   <= 1'b0;
                pinSync[i] <= 1'b0;
            end else begin
                s1Reg[i] <= pinRaw[i];
                s2Reg[i] <= s1Reg[i];
                s3Reg[i] <= s2Reg[i];
                if (s2Reg[i] == s3Reg[i]) begin
                    pinSync[i] <= s3Reg[i];
                end
            end
        end
    end
endmodule // flrs_sync

//--- tb/flrs_fan_ctrl_bench.sv
// self-checking bench for the fan lock/restart/soft-start controller
`timescale 1ns/1ns
module flrs_fan_ctrl_bench;
    localparam int OFF_T = 200;
    localparam int ON_T  = 1200;
    localparam int QS_T  = 1500;
    localparam int LK_T  = 1200;
    localparam int HALF  = 500;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic pwmIn = 1'b0;
    logic supplyHigh = 1'b0;
    logic freeRun = 1'b0;
    logic hallSet = 1'b0;
    logic hallPos, tachOutput, tachOutputEn, hallAmpEn;
    logic bridgeOutA, bridgeOutB, bridgeOutEn;
    int   miscompares = 0;
    int   compares = 0;
    int   cycles = 0;
    int   n, hi, seedVal;
    logic pwm, hall;

    // 25 MHz clock
    always #20 clk = ~clk;

    flrs_fan_ctrl #(.OFF_CYC(OFF_T), .ON_CYC(ON_T), .QS_CYC(QS_T), .START_CYC(1100),
                    .LOCK_DET_CYC(LK_T)) i_dut (
        .clk(clk), .resetn(resetn), .pwmIn(pwmIn), .tachOutput(tachOutput),
        .tachOutputEn(tachOutputEn), .hallPos(hallPos), .supplyHigh(supplyHigh),
        .hallAmpEn(hallAmpEn), .bridgeOutA(bridgeOutA), .bridgeOutB(bridgeOutB),
        .bridgeOutEn(bridgeOutEn));

    flrs_motor_model i_motor (
        .clk(clk), .bridgeOutA(bridgeOutA), .bridgeOutB(bridgeOutB),
        .bridgeOutEn(bridgeOutEn), .freeRun(freeRun), .hallSet(hallSet), .hallPos(hallPos));

    task automatic wrap_up();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // outputs packed as enable, A, B, tach pull-down
    function automatic logic [3:0] outs();
        return {bridgeOutEn, bridgeOutA, bridgeOutB, tachOutputEn};
    endfunction

    function automatic logic [3:0] run_exp(input logic p, input logic h);
        return {1'b1, p & h, p & ~h, h};
    endfunction

    task automatic step(input int k);
        repeat (k) @(negedge clk);
    endtask

    // edges for which output A keeps the given level
    task automatic run_len(input logic lvl, output int len);
        len = 0;
        while (bridgeOutA === lvl && len < 20000) begin
            @(negedge clk);
            len++;
        end
    endtask

    task automatic count_high(input int k, output int h);
        h = 0;
        repeat (k) begin
            @(negedge clk);
            if (bridgeOutA === 1'b1) h++;
        end
    endtask

    // pwm pulse train out of standby; output A high edges counted over 1000 cycles
    task automatic train(input int per, input int on, output int h);
        pwmIn = 1'b0;
        step(QS_T + 20);
        fork
            begin
                step(6);
                count_high(1000, h);
            end
            repeat (3) begin
                pwmIn = 1'b1;
                step(on);
                pwmIn = 1'b0;
                step(per - on);
            end
        join
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        seedVal = $urandom(32'h453B);
        step(4);
        check({outs(), hallAmpEn}, 5'h00);
        resetn = 1'b1;
        // commutation against random pwm and hall levels
        pwmIn = 1'b1;
        step(2);
        hallSet = 1'b1;
        step(8);
        for (int i = 0; i < 24; i++) begin
            pwm = ($urandom % 4) != 0;
            hall = $urandom % 2;
            pwmIn = pwm;
            hallSet = hall;
            step(6);
            check(outs(), run_exp(pwm, hall));
        end
        check(tachOutput, 1'b0);
        $display("commutation test done");
        // locked rotor: off time, restart pulse, repetition, recovery
        pwmIn = 1'b1;
        hallSet = 1'b1;
        step(6);
        hallSet = 1'b0;
        step(6);
        n = 0;
        while (bridgeOutB === 1'b1 && n < LK_T + 50) begin
            step(1);
            n++;
        end
        check(outs(), 4'h8);
        run_len(1'b0, n);
        check(n, OFF_T);
        check(outs(), 4'hC);
        run_len(1'b1, n);
        check(n, ON_T);
        run_len(1'b0, n);
        check(n, OFF_T);
        freeRun = 1'b1;
        step(60);
        hi = 0;
        repeat (1500) begin
            @(negedge clk);
            if (bridgeOutA === bridgeOutB) hi++;
        end
        check(hi, 0);
        freeRun = 1'b0;
        hallSet = 1'b1;
        $display("lock test done");
        // standby entry, refused hall changes, immediate start and 25 kHz chop
        supplyHigh = 1'b1;
        pwmIn = 1'b0;
        n = 0;
        while (bridgeOutEn === 1'b1 && n < 3000) begin
            step(1);
            n++;
        end
        check((n >= QS_T) && (n <= QS_T + 6), 1'b1);
        check({outs(), hallAmpEn}, 5'h00);
        repeat (4) begin
            hallSet = ~hallSet;
            step(8);
            check(outs(), 4'h0);
        end
        step(LK_T + 100);
        pwmIn = 1'b1;
        step(6);
        check(outs(), run_exp(1'b1, 1'b1));
        count_high(2 * HALF, hi);
        check(hi, HALF);
        $display("standby and chop test done");
        // low supply: conduction stretched after a random short pwm pulse
        pwmIn = 1'b0;
        step(QS_T + 20);
        supplyHigh = 1'b0;
        pwmIn = 1'b1;
        n = $urandom_range(400, 2);
        fork
            count_high(700, hi);
            begin
                step(n);
                pwmIn = 1'b0;
            end
        join
        check(hi, HALF);
        $display("low supply stretch test done");
        // low supply: 25 kHz train with random low duty, 50 kHz train with random duty up to 90%
        train(1000, $urandom_range(450, 2), hi);
        check((hi >= HALF) && (hi <= HALF + 2), 1'b1);
        train(500, $urandom_range(450, 2), hi);
        check(hi, 2 * HALF);
        $display("low supply duty test done");
        wrap_up();
    end
endmodule // flrs_fan_ctrl_bench

//--- tb/flrs_motor_model.sv
// rotor and hall sensor model that turns only while the bridge applies torque
`timescale 1ns/1ns
module flrs_motor_model #(
    parameter int unsigned SPIN_CYC = 20
) (
    // clock
    input  wire logic clk,
    // bridge drive from the controller
    input  wire logic bridgeOutA,
    input  wire logic bridgeOutB,
    input  wire logic bridgeOutEn,
    // rotor handling by the bench: free to turn, or held at a set polarity
    input  wire logic freeRun,
    input  wire logic hallSet,
    // hall comparator result
    output logic      hallPos
);
    int unsigned spinCnt = 0;
    logic        spinPol = 1'b0;

    // rotor advances one pole after SPIN_CYC driven cycles; held rotor follows bench
    always @(posedge clk) begin
        if (freeRun && bridgeOutEn && (bridgeOutA != bridgeOutB)) begin
            if (spinCnt >= SPIN_CYC - 1) begin
                spinCnt <= 0;
                spinPol <= ~spinPol;
            end else begin
                spinCnt <= spinCnt + 1;
            end
        end else if (!freeRun) begin
            spinPol <= hallSet;
        end
    end

    assign hallPos = freeRun ? spinPol : hallSet; // no drive, no rotation
endmodule // flrs_motor_model
